// [pkg/usb_serial_engine_status_pkg.sv]
// constants and types shared by the serial engine status flag logic
package usb_serial_engine_status_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0]  SERIAL_ENGINE_STATUS_OFS = 8'h50;
    localparam logic [31:0] SERIAL_ENGINE_STATUS_RST = 32'h0000_0000;

    // ==========================================================
    // field positions inside serial_engine_status
    localparam int BIT_DATA_PID_SEQUENCE_FAULT = 31;
    localparam int BIT_HANDSHAKE_OK_SEEN       = 30;
    localparam int BIT_HALT_HANDSHAKE_SEEN     = 29;
    localparam int BIT_REFUSE_HANDSHAKE_SEEN   = 28;
    localparam int BIT_RX_TIMEOUT              = 27;
    localparam int BIT_RX_OVERFLOW             = 26;
    localparam int BIT_STUFF_FAULT             = 25;
    localparam int BIT_CHECKSUM_FAULT          = 24;
    localparam int BIT_BUS_RESET               = 19;
    localparam int BIT_TRANSFER_DONE           = 18;
    localparam int BIT_CONTROL_TOKEN_SEEN      = 17;
    localparam int BIT_CONNECTED               = 16;
    localparam int BIT_RESUME                  = 11;
    localparam int BIT_SUPPLY_OVERLOAD         = 10;
    localparam int SPEED_LSB                   = 8;
    localparam int BIT_SUSPENDED               = 4;
    localparam int LINE_STATE_LSB              = 2;
    localparam int BIT_SUPPLY_PRESENT          = 0;

    // write-one-to-clear single-bit flags
    localparam logic [31:0] STICKY_MASK = 32'hff0f_0810;

    // ==========================================================
    // attached device speed codes
    localparam logic [1:0] SPEED_NONE    = 2'h0;
    localparam logic [1:0] SPEED_LOW     = 2'h1;
    localparam logic [1:0] SPEED_FULL    = 2'h2;
    localparam logic [1:0] SPEED_ILLEGAL = 2'h3;

    // ==========================================================
    // timing
    localparam int CLK_MHZ      = 250;
    localparam int ACK_WAIT_NS  = 1000;
    localparam int ACK_WAIT_CYC = (ACK_WAIT_NS * CLK_MHZ) / 1000;
    localparam int ACK_WAIT_W   = 9;
    localparam int SYNC_W       = 4;

    // ==========================================================
    // handshake wait machine
    typedef enum logic {
        ACK_IDLE,
        ACK_WAITING
    } ack_wait_t;

endpackage : usb_serial_engine_status_pkg

// [rtl/pin_input_sync.sv]
// three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/100ps

module pin_input_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // raw pins and filtered result
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_pin_sync
);

    // ==========================================================
    // synchroniser stages
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // per bit: first stage feeds only the second; output moves on agreement
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                meta_r[b]     <= 1'b0;
                stage2_r[b]   <= 1'b0;
                stage3_r[b]   <= 1'b0;
                o_pin_sync[b] <= 1'b0;
            end else begin
                meta_r[b]   <= i_pin[b];
                stage2_r[b] <= meta_r[b];
                stage3_r[b] <= stage2_r[b];
                if (stage2_r[b] == stage3_r[b]) begin
                    o_pin_sync[b] <= stage3_r[b]; // single-cycle glitch is dropped
                end
            end
        end
    end

endmodule : pin_input_sync

// [rtl/usb_serial_engine_status_flags.sv]
// status flag register of the usb serial interface engine, avalon-mm slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps

// Function
// - device: data after setup carrying data1 sets sequence fault
// - device: out data pid differing from buffer word pid sets sequence fault
// - host: in data with unexpected pid sets sequence fault
// - any ack handshake sets handshake ok flag, both roles
// - no ack, stall or nak within turnaround limit sets receive timeout, both roles
// - receiver overrun sets receive overflow flag
// - bit stuffing violation sets stuffing fault flag
// - crc failure sets checksum fault flag
// - device: host bus reset sets bus reset flag
// - device: in/out packet with final buffer bit sets transfer done
// - host: setup sent with no data stage sets transfer done
// - host: in with final bit or zero length, out with final bit, done
// - device: each received setup sets control token flag
// - resume signalling from the far end sets resume flag
// - read-only supply overload indication
// - host: two-bit attached speed, 00 none, 01 low, 10 full
// - suspend flag when neither keep-alive nor frame start is enabled
module usb_serial_engine_status_flags (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // avalon-mm register slave
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // role and frame generation settings
    input  wire logic        i_host_mode,
    input  wire logic        i_keepalive_en,
    input  wire logic        i_sof_en,
    // receive data packet events
    input  wire logic        i_data_rx_done,
    input  wire logic        i_data_rx_after_setup,
    input  wire logic        i_data_rx_pid1,
    input  wire logic        i_bufctl_pid1,
    // handshake and receiver events
    input  wire logic        i_handshake_ack,
    input  wire logic        i_handshake_stall,
    input  wire logic        i_handshake_nak,
    input  wire logic        i_ack_wait_start,
    input  wire logic        i_rx_overflow,
    input  wire logic        i_rx_stuff_err,
    input  wire logic        i_rx_crc_err,
    // packet completion events
    input  wire logic        i_pkt_done,
    input  wire logic        i_pkt_is_setup,
    input  wire logic        i_pkt_is_in,
    input  wire logic        i_final_buffer_bit,
    input  wire logic        i_pkt_zero_len,
    input  wire logic        i_data_stage_req,
    // bus events
    input  wire logic        i_control_token_rx,
    input  wire logic        i_bus_reset_seen,
    input  wire logic        i_resume_seen,
    input  wire logic        i_suspend_idle,
    input  wire logic        i_connect_seen,
    input  wire logic        i_speed_update,
    input  wire logic [1:0]  i_dev_speed,
    // pins
    input  wire logic [1:0]  i_line_state,
    input  wire logic        i_supply_present,
    input  wire logic        i_supply_overload
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [31:0]                                   sticky;
        logic [1:0]                                    speed;
        usb_serial_engine_status_pkg::ack_wait_t                 ack_st;
        logic [usb_serial_engine_status_pkg::ACK_WAIT_W-1:0]     ack_cnt;
        logic                                          wait_rq;
        logic [31:0]                                   rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        sticky:  usb_serial_engine_status_pkg::SERIAL_ENGINE_STATUS_RST,
        speed:   usb_serial_engine_status_pkg::SPEED_NONE,
        ack_st:  usb_serial_engine_status_pkg::ACK_IDLE,
        ack_cnt: '0,
        wait_rq: 1'b1,
        rdata:   32'h0000_0000
    };
    localparam logic [usb_serial_engine_status_pkg::ACK_WAIT_W-1:0] ACK_LAST =
        usb_serial_engine_status_pkg::ACK_WAIT_W'(usb_serial_engine_status_pkg::ACK_WAIT_CYC - 1);

    state_t      st_r;
    state_t      st_nxt;
    logic [3:0]  pins_sync;
    logic [31:0] set_v;
    logic [31:0] clr_v;
    logic [31:0] view;
    logic [31:0] be_mask;
    logic        hit;
    logic        taken;
    logic        seq_fault;
    logic        done_dev;
    logic        done_host;
    logic        any_hs;

    // ==========================================================
    // pin synchronisers
    pin_input_sync #(
        .WIDTH (usb_serial_engine_status_pkg::SYNC_W)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      ({i_supply_overload, i_supply_present, i_line_state}),
        .o_pin_sync (pins_sync)
    );

    // ==========================================================
    // event decode
    assign seq_fault = i_data_rx_done & (i_host_mode ? (i_data_rx_pid1 != i_bufctl_pid1)
                     : (i_data_rx_after_setup ? i_data_rx_pid1
                     : (i_data_rx_pid1 != i_bufctl_pid1)));
    // device: data packet with final buffer bit, setup data excluded
    assign done_dev  = ~i_host_mode & i_pkt_done & ~i_pkt_is_setup & i_final_buffer_bit;
    assign done_host = i_host_mode & i_pkt_done &
                       ((i_pkt_is_setup & ~i_data_stage_req) |
                        (~i_pkt_is_setup & i_pkt_is_in & (i_final_buffer_bit | i_pkt_zero_len)) |
                        (~i_pkt_is_setup & ~i_pkt_is_in & i_final_buffer_bit));
    assign any_hs    = i_handshake_ack | i_handshake_stall | i_handshake_nak;
    assign hit       = (i_avs_address == usb_serial_engine_status_pkg::SERIAL_ENGINE_STATUS_OFS);
    assign taken     = (i_avs_read | i_avs_write) & ~st_r.wait_rq;
    assign be_mask   = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                        {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // ==========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        set_v  = 32'h0000_0000;
        clr_v  = 32'h0000_0000;
        // read view: sticky bits plus live fields
        view = st_r.sticky;
        view[usb_serial_engine_status_pkg::SPEED_LSB +: 2]      = st_r.speed;
        view[usb_serial_engine_status_pkg::BIT_SUPPLY_OVERLOAD] = pins_sync[3];
        view[usb_serial_engine_status_pkg::BIT_SUPPLY_PRESENT]  = pins_sync[2];
        view[usb_serial_engine_status_pkg::LINE_STATE_LSB +: 2] = pins_sync[1:0];

        // handshake wait: any handshake ends it, the limit raises a timeout
        unique case (st_r.ack_st)
            usb_serial_engine_status_pkg::ACK_IDLE: begin
                if (i_ack_wait_start) begin
                    st_nxt.ack_st  = usb_serial_engine_status_pkg::ACK_WAITING;
                    st_nxt.ack_cnt = '0;
                end
            end
            usb_serial_engine_status_pkg::ACK_WAITING: begin
                if (any_hs) begin
                    st_nxt.ack_st = usb_serial_engine_status_pkg::ACK_IDLE;
                end else if (st_r.ack_cnt == ACK_LAST) begin
                    st_nxt.ack_st = usb_serial_engine_status_pkg::ACK_IDLE;
                    set_v[usb_serial_engine_status_pkg::BIT_RX_TIMEOUT] = 1'b1;
                end else begin
                    st_nxt.ack_cnt = st_r.ack_cnt + 1'b1;
                end
            end
        endcase

        // flag set sources
        set_v[usb_serial_engine_status_pkg::BIT_DATA_PID_SEQUENCE_FAULT] = seq_fault;
        set_v[usb_serial_engine_status_pkg::BIT_HANDSHAKE_OK_SEEN]   = i_handshake_ack;
        set_v[usb_serial_engine_status_pkg::BIT_HALT_HANDSHAKE_SEEN] = i_host_mode & i_handshake_stall;
        set_v[usb_serial_engine_status_pkg::BIT_REFUSE_HANDSHAKE_SEEN] = i_host_mode & i_handshake_nak;
        set_v[usb_serial_engine_status_pkg::BIT_RX_OVERFLOW]     = i_rx_overflow;
        set_v[usb_serial_engine_status_pkg::BIT_STUFF_FAULT]     = i_rx_stuff_err;
        set_v[usb_serial_engine_status_pkg::BIT_CHECKSUM_FAULT]  = i_rx_crc_err;
        set_v[usb_serial_engine_status_pkg::BIT_BUS_RESET]       = ~i_host_mode & i_bus_reset_seen;
        set_v[usb_serial_engine_status_pkg::BIT_TRANSFER_DONE]   = done_dev | done_host;
        set_v[usb_serial_engine_status_pkg::BIT_CONTROL_TOKEN_SEEN] = ~i_host_mode & i_control_token_rx;
        set_v[usb_serial_engine_status_pkg::BIT_CONNECTED]       = i_connect_seen;
        set_v[usb_serial_engine_status_pkg::BIT_RESUME]          = i_resume_seen;
        set_v[usb_serial_engine_status_pkg::BIT_SUSPENDED]       = i_suspend_idle & ~i_keepalive_en
                                                         & ~i_sof_en;

        // bus slave: one wait cycle, then the request is taken
        if ((i_avs_read | i_avs_write) & st_r.wait_rq) begin
            st_nxt.wait_rq = 1'b0;
            st_nxt.rdata   = hit ? view : 32'h0000_0000; // unmapped reads as zero
        end else if (taken) begin
            st_nxt.wait_rq = 1'b1;
            if (i_avs_write & hit) begin
                clr_v = i_avs_writedata & be_mask; // read-only bits dropped below
            end
        end

        // set wins over a clear in the same cycle
        st_nxt.sticky = (st_r.sticky & ~(clr_v & usb_serial_engine_status_pkg::STICKY_MASK))
                      | (set_v & usb_serial_engine_status_pkg::STICKY_MASK);
        st_nxt.speed  = st_r.speed & ~clr_v[usb_serial_engine_status_pkg::SPEED_LSB +: 2];
        // reserved code 11 never stored
        if (i_host_mode & i_speed_update & (i_dev_speed != usb_serial_engine_status_pkg::SPEED_ILLEGAL)) begin
            st_nxt.speed = i_dev_speed;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign o_avs_readdata    = st_r.rdata;
    assign o_avs_waitrequest = st_r.wait_rq;

    // ==========================================================
    // assertions
    property p_seq_setup;
        @(posedge i_core_clk) disable iff (i_rst)
        (!i_host_mode && i_data_rx_done && i_data_rx_after_setup && i_data_rx_pid1)
        |=> st_r.sticky[usb_serial_engine_status_pkg::BIT_DATA_PID_SEQUENCE_FAULT];
    endproperty
    a_seq_setup: assert property (p_seq_setup) else $error("setup data1 not flagged");

    property p_seq_out;
        @(posedge i_core_clk) disable iff (i_rst)
        (!i_host_mode && i_data_rx_done && !i_data_rx_after_setup
         && (i_data_rx_pid1 != i_bufctl_pid1))
        |=> st_r.sticky[usb_serial_engine_status_pkg::BIT_DATA_PID_SEQUENCE_FAULT];
    endproperty
    a_seq_out: assert property (p_seq_out) else $error("out pid mismatch not flagged");

    property p_seq_host;
        @(posedge i_core_clk) disable iff (i_rst)
        (!st_r.sticky[usb_serial_engine_status_pkg::BIT_DATA_PID_SEQUENCE_FAULT] && i_host_mode
         && i_data_rx_done && (i_data_rx_pid1 == i_bufctl_pid1))
        |=> !st_r.sticky[usb_serial_engine_status_pkg::BIT_DATA_PID_SEQUENCE_FAULT];
    endproperty
    a_seq_host: assert property (p_seq_host) else $error("matching pid flagged");

    property p_ack;
        @(posedge i_core_clk) disable iff (i_rst)
        i_handshake_ack |=> st_r.sticky[usb_serial_engine_status_pkg::BIT_HANDSHAKE_OK_SEEN];
    endproperty
    a_ack: assert property (p_ack) else $error("ack not flagged");

    property p_timeout;
        @(posedge i_core_clk) disable iff (i_rst)
        (st_r.ack_st == usb_serial_engine_status_pkg::ACK_IDLE && i_ack_wait_start)
        ##1 (!any_hs && !i_ack_wait_start) [*8]
        |-> st_r.ack_st == usb_serial_engine_status_pkg::ACK_WAITING && st_r.ack_cnt == 9'h007;
    endproperty
    a_timeout: assert property (p_timeout) else $error("ack wait count wrong");

    property p_timeout_flag;
        @(posedge i_core_clk) disable iff (i_rst)
        (st_r.ack_st == usb_serial_engine_status_pkg::ACK_WAITING && st_r.ack_cnt == ACK_LAST && !any_hs)
        |=> st_r.sticky[usb_serial_engine_status_pkg::BIT_RX_TIMEOUT]
            && st_r.ack_st == usb_serial_engine_status_pkg::ACK_IDLE;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("timeout not raised");

    property p_stuff;
        @(posedge i_core_clk) disable iff (i_rst)
        i_rx_stuff_err |=> st_r.sticky[usb_serial_engine_status_pkg::BIT_STUFF_FAULT];
    endproperty
    a_stuff: assert property (p_stuff) else $error("stuff fault not flagged");

    property p_done_setup;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_host_mode && i_pkt_done && i_pkt_is_setup && !i_data_stage_req)
        |=> st_r.sticky[usb_serial_engine_status_pkg::BIT_TRANSFER_DONE];
    endproperty
    a_done_setup: assert property (p_done_setup) else $error("setup done missing");

    property p_done_dev;
        @(posedge i_core_clk) disable iff (i_rst)
        (!st_r.sticky[usb_serial_engine_status_pkg::BIT_TRANSFER_DONE] && !i_host_mode
         && i_pkt_done && !i_final_buffer_bit)
        |=> !st_r.sticky[usb_serial_engine_status_pkg::BIT_TRANSFER_DONE];
    endproperty
    a_done_dev: assert property (p_done_dev) else $error("done without final bit");

    property p_w1c;
        @(posedge i_core_clk) disable iff (i_rst)
        (taken && i_avs_write && hit && i_avs_byteenable[3] && !i_handshake_ack
         && i_avs_writedata[usb_serial_engine_status_pkg::BIT_HANDSHAKE_OK_SEEN])
        |=> !st_r.sticky[usb_serial_engine_status_pkg::BIT_HANDSHAKE_OK_SEEN];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_speed;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_host_mode && i_speed_update && i_dev_speed != usb_serial_engine_status_pkg::SPEED_ILLEGAL)
        |=> st_r.speed == $past(i_dev_speed);
    endproperty
    a_speed: assert property (p_speed) else $error("speed not loaded");

endmodule : usb_serial_engine_status_flags

// [testbench/usb_far_end_model.sv]
// far side model: serial engine events and usb pins seen by the status block
`timescale 1ns/100ps

module usb_far_end_model (
    // clock
    input  wire logic        i_core_clk,
    // event pulses and attached speed code
    output logic      [14:0] o_pulse,
    output logic      [1:0]  o_dev_speed,
    // pins
    output logic      [1:0]  o_line_state,
    output logic             o_supply_present,
    output logic             o_supply_overload
);
    // ==========================================================
    // quiet bus from time zero
    initial begin
        o_pulse           = 15'h0000;
        o_dev_speed       = 2'h0;
        o_line_state      = 2'h0;
        o_supply_present  = 1'b0;
        o_supply_overload = 1'b0;
    end

    // ==========================================================
    // one-cycle event launched just after a rising edge
    task automatic fire(input int idx, input logic [1:0] spd);
        @(posedge i_core_clk);
        o_pulse     <= 15'h0001 << idx;
        o_dev_speed <= spd;
        @(posedge i_core_clk);
        o_pulse <= 15'h0000;
    endtask : fire

    // pins are slow; the bench waits out the synchroniser itself
    task automatic set_pins(input logic [1:0] ls, input logic vp, input logic oc);
        @(posedge i_core_clk);
        o_line_state      <= ls;
        o_supply_present  <= vp;
        o_supply_overload <= oc;
    endtask : set_pins
endmodule : usb_far_end_model

// [testbench/usb_serial_engine_status_flags_tb.sv]
// self-checking bench for the serial engine status flag register
`timescale 1ns/100ps

module usb_serial_engine_status_flags_tb;
    logic        core_clk;
    logic        rst;
    logic [7:0]  address;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [10:0] lv;
    wire  [31:0] readdata;
    wire         waitreq;
    wire  [14:0] pulse;
    wire  [1:0]  spd;
    wire  [1:0]  ls;
    wire         vp;
    wire         oc;
    int          n_mismatch;
    int          comparisons;
    int          cycles;

    // ==========================================================
    // design and far side
    usb_serial_engine_status_flags i_dut (
        .i_core_clk(core_clk), .i_rst(rst), .i_avs_address(address), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .i_host_mode(lv[0]),
        .i_keepalive_en(lv[1]), .i_sof_en(lv[2]), .i_data_rx_done(pulse[0]),
        .i_data_rx_after_setup(lv[3]), .i_data_rx_pid1(lv[4]), .i_bufctl_pid1(lv[5]),
        .i_handshake_ack(pulse[1]), .i_handshake_stall(pulse[2]), .i_handshake_nak(pulse[3]),
        .i_ack_wait_start(pulse[4]), .i_rx_overflow(pulse[5]), .i_rx_stuff_err(pulse[6]),
        .i_rx_crc_err(pulse[7]), .i_pkt_done(pulse[8]), .i_pkt_is_setup(lv[6]),
        .i_pkt_is_in(lv[7]), .i_final_buffer_bit(lv[8]), .i_pkt_zero_len(lv[9]),
        .i_data_stage_req(lv[10]), .i_control_token_rx(pulse[9]),
        .i_bus_reset_seen(pulse[10]), .i_resume_seen(pulse[11]), .i_suspend_idle(pulse[12]),
        .i_connect_seen(pulse[13]), .i_speed_update(pulse[14]), .i_dev_speed(spd),
        .i_line_state(ls), .i_supply_present(vp), .i_supply_overload(oc));
    usb_far_end_model u_far (
        .i_core_clk(core_clk), .o_pulse(pulse), .o_dev_speed(spd), .o_line_state(ls),
        .o_supply_present(vp), .o_supply_overload(oc));

    // ==========================================================
    // clock and hang guard; 5000 cycles is well past the full run
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ==========================================================
    // avalon master: request held until waitrequest is sampled low at a rising edge
    // values read right after the edge are the pre-edge ones the slave also sampled
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
        @(posedge core_clk);
        address <= a;
        rd      <= ~w;
        wr      <= w;
        wdata   <= d;
        be      <= b;
        do begin
            @(posedge core_clk);
        end while (waitreq !== 1'b0);
        q = readdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : av

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(q, exp);
    endtask : rd_chk

    // fire one event, see its flag, clear all, see it gone
    task automatic ev(input int idx, input logic [1:0] s, input logic [31:0] exp);
        logic [31:0] q;
        u_far.fire(idx, s);
        rd_chk(8'h50, exp);
        av(1'b1, 8'h50, 32'hffff_ffff, 4'hf, q);
        rd_chk(8'h50, 32'h0000_0000);
    endtask : ev

    // ==========================================================
    // scenarios
    task automatic t_registers();
        logic [31:0] q;
        rd_chk(8'h50, usb_serial_engine_status_pkg::SERIAL_ENGINE_STATUS_RST);
        u_far.set_pins(2'h3, 1'b1, 1'b1);
        repeat (8) @(posedge core_clk);
        rd_chk(8'h50, 32'h0000_040d);
        av(1'b1, 8'h50, 32'hffff_ffff, 4'hf, q);
        rd_chk(8'h50, 32'h0000_040d);
        u_far.set_pins(2'h0, 1'b0, 1'b0);
        repeat (8) @(posedge core_clk);
        lv <= 11'h010; // device out, pid mismatch
        u_far.fire(0, 2'h0);
        av(1'b1, 8'h50, 32'h0000_0000, 4'hf, q);
        av(1'b1, 8'h50, 32'hffff_ffff, 4'h7, q);
        av(1'b1, 8'h54, 32'hffff_ffff, 4'hf, q);
        rd_chk(8'h54, 32'h0000_0000);
        rd_chk(8'h50, 32'h8000_0000);
        av(1'b1, 8'h50, 32'h8000_0000, 4'h8, q);
        rd_chk(8'h50, 32'h0000_0000);
    endtask : t_registers

    task automatic t_flags();
        lv <= 11'h000;
        ev(1, 2'h0, 32'h4000_0000);
        ev(5, 2'h0, 32'h0400_0000);
        ev(6, 2'h0, 32'h0200_0000);
        ev(7, 2'h0, 32'h0100_0000);
        ev(10, 2'h0, 32'h0008_0000);
        ev(9, 2'h0, 32'h0002_0000);
        ev(11, 2'h0, 32'h0000_0800);
        ev(13, 2'h0, 32'h0001_0000);
        ev(2, 2'h0, 32'h0000_0000);
        lv <= 11'h001;
        ev(10, 2'h0, 32'h0000_0000);
        ev(9, 2'h0, 32'h0000_0000);
        ev(2, 2'h0, 32'h2000_0000);
        ev(3, 2'h0, 32'h1000_0000);
        ev(1, 2'h0, 32'h4000_0000);
        ev(11, 2'h0, 32'h0000_0800);
    endtask : t_flags

    task automatic t_sequence();
        lv <= 11'h038;
        ev(0, 2'h0, 32'h8000_0000);
        lv <= 11'h028; // data0 after setup is legal whatever the buffer word says
        ev(0, 2'h0, 32'h0000_0000);
        lv <= 11'h010;
        ev(0, 2'h0, 32'h8000_0000);
        lv <= 11'h000;
        ev(0, 2'h0, 32'h0000_0000);
        lv <= 11'h021;
        ev(0, 2'h0, 32'h8000_0000);
        lv <= 11'h031;
        ev(0, 2'h0, 32'h0000_0000);
    endtask : t_sequence

    task automatic t_done();
        logic [10:0] cfg [8];
        logic [31:0] exp [8];
        cfg = '{11'h100, 11'h000, 11'h041, 11'h441, 11'h181, 11'h281, 11'h081, 11'h101};
        exp = '{32'h4_0000, 32'h0, 32'h4_0000, 32'h0, 32'h4_0000, 32'h4_0000, 32'h0, 32'h4_0000};
        for (int i = 0; i < 8; i++) begin
            lv <= cfg[i];
            ev(8, 2'h0, exp[i]);
        end
    endtask : t_done

    task automatic t_suspend();
        lv <= 11'h000;
        ev(12, 2'h0, 32'h0000_0010);
        lv <= 11'h004;
        ev(12, 2'h0, 32'h0000_0000);
        lv <= 11'h002;
        ev(12, 2'h0, 32'h0000_0000);
    endtask : t_suspend

    task automatic t_speed();
        lv <= 11'h000; // speed is a host-role field
        ev(14, 2'h1, 32'h0000_0000);
        lv <= 11'h001;
        ev(14, 2'h1, 32'h0000_0100);
        ev(14, 2'h2, 32'h0000_0200);
        u_far.fire(14, 2'h1);
        u_far.fire(14, 2'h3);
        rd_chk(8'h50, 32'h0000_0100);
        ev(14, 2'h0, 32'h0000_0000);
    endtask : t_speed

    // counter must expire only after the full turnaround wait
    task automatic t_timeout();
        logic [31:0] q;
        lv <= 11'h000;
        u_far.fire(4, 2'h0);
        repeat (usb_serial_engine_status_pkg::ACK_WAIT_CYC - 12) @(posedge core_clk);
        rd_chk(8'h50, 32'h0000_0000);
        repeat (20) @(posedge core_clk);
        rd_chk(8'h50, 32'h0800_0000);
        av(1'b1, 8'h50, 32'hffff_ffff, 4'hf, q);
        u_far.fire(4, 2'h0);
        u_far.fire(1, 2'h0);
        repeat (usb_serial_engine_status_pkg::ACK_WAIT_CYC + 20) @(posedge core_clk);
        rd_chk(8'h50, 32'h4000_0000);
    endtask : t_timeout

    // ==========================================================
    // main sequence
    initial begin
        core_clk    = 1'b0;
        rst         = 1'b1;
        address     = 8'h00;
        rd          = 1'b0;
        wr          = 1'b0;
        wdata       = 32'h0000_0000;
        be          = 4'hf;
        lv          = 11'h000;
        n_mismatch  = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_registers();
        t_flags();
        t_sequence();
        t_done();
        t_suspend();
        t_speed();
        t_timeout();
        report_and_stop();
    end
endmodule : usb_serial_engine_status_flags_tb
